// file: design/arc_pkg.sv
// Constants and types for the priority result, compare and conversion clock block
// What this block does
// - Storing a priority conversion result sets the result-present flag, bit 0.
// - Reading the priority low result register clears the result-present flag.
// - A store before both result halves were read sets the overrun flag, bit 1.
// - Reading the overrun flag clears it.
// - Compare values: 10 bits, upper 8 in high register, low 2 in bits 7:6.
// - Conversion length is based on 46 conversion clocks.
// - Sample-hold field bits 7:4 selects 8 to 512 conversion clocks by code.
// - Prescaler field bits 2:0 picks conversion clock; 000 means undivided fc.
// - Longer sample-hold adds its extra clocks to the total conversion time.
// - Priority conversion stores into the result pair, then normal conversion resumes.
package arc_pkg;
	// Word indexes on the register bus
	localparam logic [2:0] ADR_PRIO_LO = 3'h0;
	localparam logic [2:0] ADR_PRIO_HI = 3'h1;
	localparam logic [2:0] ADR_CMP0_LO = 3'h2;
	localparam logic [2:0] ADR_CMP0_HI = 3'h3;
	localparam logic [2:0] ADR_CMP1_LO = 3'h4;
	localparam logic [2:0] ADR_CMP1_HI = 3'h5;
	localparam logic [2:0] ADR_CLK_SET = 3'h6;
	localparam logic [2:0] ADR_STATUS = 3'h7;
	// Field positions and reset values
	localparam int LO_PRESENT_BIT = 0;
	localparam int LO_OVR_BIT = 1;
	localparam logic [7:0] CLK_SET_RST = 8'h80;
	localparam logic [7:0] CLK_SET_MASK = 8'hF7;
	// Conversion timing in conversion clocks
	localparam logic [9:0] CONV_BASE_CLKS = 10'h02E;
	localparam logic [9:0] SH_BASE_CLKS = 10'h008;
	localparam logic [9:0] CONV_TAIL_CLKS = CONV_BASE_CLKS - SH_BASE_CLKS;
	// Prescaler and sample-hold codes
	localparam logic [2:0] PRE_DIV1 = 3'h0;
	localparam logic [2:0] PRE_DIV2 = 3'h1;
	localparam logic [2:0] PRE_DIV4 = 3'h2;
	localparam logic [3:0] SH_8 = 4'h8;
	localparam logic [3:0] SH_16 = 4'h9;
	localparam logic [3:0] SH_24 = 4'hA;
	localparam logic [3:0] SH_32 = 4'hB;
	localparam logic [3:0] SH_64 = 4'h3;
	localparam logic [3:0] SH_128 = 4'hC;
	localparam logic [3:0] SH_512 = 4'hD;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b10
	} arc_state_t;

	// Reserved codes fall back to the shortest sample time
	function automatic logic [9:0] arc_sh_clocks(input logic [3:0] code);
		case (code)
			SH_16: arc_sh_clocks = 10'h010;
			SH_24: arc_sh_clocks = 10'h018;
			SH_32: arc_sh_clocks = 10'h020;
			SH_64: arc_sh_clocks = 10'h040;
			SH_128: arc_sh_clocks = 10'h080;
			SH_512: arc_sh_clocks = 10'h200;
			default: arc_sh_clocks = SH_BASE_CLKS;
		endcase
	endfunction
endpackage

// file: design/arc_top.sv
// Priority result, compare value and conversion clock block with Avalon-MM slave
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module arc_top import arc_pkg::*; (
	input wire logic clk_sys, // System clock fc
	input wire logic rst, // Synchronous reset, active high
	input wire logic [2:0] avs_address, // Word index
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Low for the answer cycle
	input wire logic prio_start, // Start a priority conversion
	input wire logic [9:0] adc_sample, // Converter output word
	input wire logic [1:0] monitor_enable, // Monitor enables per compare
	output logic prio_busy, // Priority conversion running
	output logic sample_hold, // Sample-hold phase active
	output logic conv_clk_en, // Conversion clock enable pulse
	output logic prio_store, // Result stored, normal may resume
	output logic [9:0] prio_result_bits, // Stored priority result
	output logic [9:0] compare0_bits, // Compare value 0
	output logic [9:0] compare1_bits // Compare value 1
);
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [9:0] res_reg;
	logic present_reg;
	logic ovr_reg;
	logic pend_hi_reg;
	logic pend_lo_reg;
	logic [9:0] cmp_reg [2];
	logic [7:0] clk_set_reg;
	arc_state_t state_reg;
	arc_state_t state_next;
	logic [9:0] cnt_reg;
	logic [9:0] cnt_next;
	logic [9:0] sh_cur_reg;
	logic [1:0] mask_cur_reg;
	logic [1:0] pre_cnt_reg;
	logic tick_reg;
	logic busy_reg;
	logic samp_reg;
	logic store_reg;
	logic [7:0] rd_mux;

	// Bus request decode; side effects act on the capture edge
	wire take = (avs_read | avs_write) & wait_reg;
	wire rd_take = take & avs_read;
	wire wr_take = take & avs_write;
	wire rd_lo = rd_take & (avs_address == ADR_PRIO_LO);
	wire rd_hi = rd_take & (avs_address == ADR_PRIO_HI);
	wire wr_clk = wr_take & (avs_address == ADR_CLK_SET);
	wire [7:0] wbyte = avs_writedata[7:0];
	wire busy = state_reg != ST_IDLE;
	wire start = prio_start & ~busy;
	wire last_tail = cnt_reg == (CONV_TAIL_CLKS - 10'h001);
	wire last_sh = cnt_reg == (sh_cur_reg - 10'h001);
	wire store = (state_reg == ST_CONVERT) & tick_reg & last_tail;
	wire [2:0] pre_sel = clk_set_reg[2:0];
	wire [1:0] div_mask = (pre_sel == PRE_DIV2) ? 2'b01 :
		(pre_sel == PRE_DIV4) ? 2'b11 : 2'b00;
	wire tick_next = busy & ((pre_cnt_reg & mask_cur_reg) == mask_cur_reg);

	// One wait state: waitrequest drops for one cycle after capture
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= ~take;
			if (rd_take) begin
				rdata_reg <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Read mux; unmapped words read as zero
	always_comb begin
		if (avs_address == ADR_PRIO_LO) begin
			rd_mux = {res_reg[1:0], 4'h0, ovr_reg, present_reg};
		end else if (avs_address == ADR_PRIO_HI) begin
			rd_mux = res_reg[9:2];
		end else if (avs_address == ADR_CMP0_LO) begin
			rd_mux = {cmp_reg[0][1:0], 6'h00};
		end else if (avs_address == ADR_CMP0_HI) begin
			rd_mux = cmp_reg[0][9:2];
		end else if (avs_address == ADR_CMP1_LO) begin
			rd_mux = {cmp_reg[1][1:0], 6'h00};
		end else if (avs_address == ADR_CMP1_HI) begin
			rd_mux = cmp_reg[1][9:2];
		end else if (avs_address == ADR_CLK_SET) begin
			rd_mux = clk_set_reg;
		end else if (avs_address == ADR_STATUS) begin
			rd_mux = {6'h00, samp_reg, busy_reg};
		end else begin
			rd_mux = 8'h00;
		end
	end

	// Result flags; a store in the clearing cycle wins
	wire present_next = store | (present_reg & ~rd_lo);
	wire ovr_next = (store & (pend_hi_reg | pend_lo_reg)) | (ovr_reg & ~rd_lo);
	// Halves tracked apart, so high-then-low fetch stays clean
	wire pend_hi_next = store | (pend_hi_reg & ~rd_hi);
	wire pend_lo_next = store | (pend_lo_reg & ~rd_lo);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			res_reg <= 10'h000;
			present_reg <= 1'b0;
			ovr_reg <= 1'b0;
			pend_hi_reg <= 1'b0;
			pend_lo_reg <= 1'b0;
		end else begin
			if (store) begin
				res_reg <= adc_sample;
			end
			present_reg <= present_next;
			ovr_reg <= ovr_next;
			pend_hi_reg <= pend_hi_next;
			pend_lo_reg <= pend_lo_next;
		end
	end

	// Compare values; writes ignored while that monitor runs
	generate
		for (genvar g = 0; g < 2; g++) begin : g_cmp
			wire [2:0] lo_adr = ADR_CMP0_LO + 3'(2 * g);
			wire open_wr = wr_take & ~monitor_enable[g];
			wire wr_lo = open_wr & (avs_address == lo_adr);
			wire wr_hi = open_wr & (avs_address == lo_adr + 3'h1);
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					cmp_reg[g] <= 10'h000;
				end else if (wr_hi) begin
					cmp_reg[g][9:2] <= wbyte;
				end else if (wr_lo) begin
					cmp_reg[g][1:0] <= wbyte[7:6];
				end
			end
		end
	endgenerate

	// Clock settings; bit 3 always reads zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_set_reg <= CLK_SET_RST;
		end else if (wr_clk) begin
			clk_set_reg <= wbyte & CLK_SET_MASK;
		end
	end

	// Sequencer next state: sample-hold clocks, then the fixed tail
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_SAMPLE;
					cnt_next = 10'h000;
				end
			end
			ST_SAMPLE: begin
				if (tick_reg && last_sh) begin
					state_next = ST_CONVERT;
					cnt_next = 10'h000;
				end else if (tick_reg) begin
					cnt_next = cnt_reg + 10'h001;
				end
			end
			ST_CONVERT: begin
				if (tick_reg && last_tail) begin
					state_next = ST_IDLE;
					cnt_next = 10'h000;
				end else if (tick_reg) begin
					cnt_next = cnt_reg + 10'h001;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = 10'h000;
			end
		endcase
	end

	// Settings latched at start, so a late write cannot bend a conversion
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sh_cur_reg <= SH_BASE_CLKS;
			mask_cur_reg <= 2'b00;
		end else if (start) begin
			sh_cur_reg <= arc_sh_clocks(clk_set_reg[7:4]);
			mask_cur_reg <= div_mask;
		end
	end

	// Sequencer state, prescaler and registered status
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 10'h000;
			pre_cnt_reg <= 2'b00;
			tick_reg <= 1'b0;
			busy_reg <= 1'b0;
			samp_reg <= 1'b0;
			store_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pre_cnt_reg <= start ? 2'b00 : pre_cnt_reg + 2'b01;
			// No pulse after the store edge; busy is still high in that cycle
			tick_reg <= tick_next & ~start & ~store;
			busy_reg <= state_next != ST_IDLE;
			samp_reg <= state_next == ST_SAMPLE;
			store_reg <= store;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign prio_busy = busy_reg;
	assign sample_hold = samp_reg;
	assign conv_clk_en = tick_reg;
	assign prio_store = store_reg;
	assign prio_result_bits = res_reg;
	assign compare0_bits = cmp_reg[0];
	assign compare1_bits = cmp_reg[1];

	// Checking helper: conversion clocks seen since start
	logic [9:0] hlp_ticks_reg;
	always_ff @(posedge clk_sys) begin
		if (rst || start) begin
			hlp_ticks_reg <= 10'h000;
		end else if (busy && tick_reg) begin
			hlp_ticks_reg <= hlp_ticks_reg + 10'h001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_present_set;
		store |=> present_reg;
	endproperty
	a_present_set: assert property (p_present_set) else $error("present flag not set");

	property p_present_clr;
		rd_lo && !store |=> !present_reg;
	endproperty
	a_present_clr: assert property (p_present_clr) else $error("present flag not cleared");

	property p_ovr_set;
		store && (pend_hi_reg || pend_lo_reg) |=> ovr_reg;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

	property p_ovr_clr;
		rd_lo && !store |=> !ovr_reg ##1 (ovr_reg == $past(store && (pend_hi_reg || pend_lo_reg)));
	endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

	property p_cmp_lo;
		rd_take && avs_address == ADR_CMP0_LO |=> avs_readdata[5:0] == 6'h00
			&& avs_readdata[7:6] == cmp_reg[0][1:0] && !avs_waitrequest;
	endproperty
	a_cmp_lo: assert property (p_cmp_lo) else $error("compare low layout wrong");

	property p_cmp_hold;
		monitor_enable[1] && wr_take |=> $stable(cmp_reg[1]);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed while monitored");

	property p_total_len;
		store |-> hlp_ticks_reg + 10'h001 == sh_cur_reg + CONV_TAIL_CLKS;
	endproperty
	a_total_len: assert property (p_total_len) else $error("conversion length wrong");

	property p_sh_len;
		state_reg == ST_SAMPLE && state_next == ST_CONVERT
			|-> hlp_ticks_reg + 10'h001 == sh_cur_reg;
	endproperty
	a_sh_len: assert property (p_sh_len) else $error("sample-hold length wrong");

	property p_div1;
		busy && mask_cur_reg == 2'b00 && !$rose(busy) |-> tick_reg;
	endproperty
	a_div1: assert property (p_div1) else $error("undivided clock skipped");

	property p_div4;
		busy && mask_cur_reg == 2'b11 && tick_reg |=> !tick_reg [*3];
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

	property p_resume;
		store |=> prio_store && !prio_busy && prio_result_bits == $past(adc_sample);
	endproperty
	a_resume: assert property (p_resume) else $error("store handshake wrong");

	c_store: cover property (store);
	c_overrun: cover property (store && pend_lo_reg);
	c_div4_done: cover property (store && mask_cur_reg == 2'b11);
	c_long_sh: cover property (store && sh_cur_reg == 10'h200);
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the priority result, compare and clock block
`timescale 1ns/1ps
module tb_top;
	import arc_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, prio_start = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [9:0] adc_sample = 10'h000, prio_result_bits, compare0_bits, compare1_bits;
	logic [1:0] monitor_enable = 2'h0;
	logic avs_waitrequest, prio_busy, sample_hold, conv_clk_en, prio_store;
	int miscompares = 0, n_compared = 0, pulses, gap;
	int sh_pulses, busy_pulses;
	logic [7:0] rd;

	arc_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .prio_start(prio_start), .adc_sample(adc_sample),
		.monitor_enable(monitor_enable), .prio_busy(prio_busy), .sample_hold(sample_hold),
		.conv_clk_en(conv_clk_en), .prio_store(prio_store), .prio_result_bits(prio_result_bits),
		.compare0_bits(compare0_bits), .compare1_bits(compare1_bits));

	// 125 MHz system clock
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bus cycles hold the request until waitrequest is sampled low
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[7:0];
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
		bus_rd(a, rd);
		chk(what, {8'h0, exp}, {8'h0, rd});
	endtask

	// Runs one priority conversion; counts conversion clock pulses and their spacing
	task automatic run_conv(input logic [3:0] sh, input logic [2:0] pre, input logic [9:0] s);
		int cyc, last;
		bus_wr(ADR_CLK_SET, {sh, 1'b0, pre});
		prio_start <= 1'b1;
		adc_sample <= s;
		@(posedge clk_sys);
		prio_start <= 1'b0;
		pulses = 0;
		sh_pulses = 0;
		busy_pulses = 0;
		gap = 0;
		last = 0;
		cyc = 0;
		while (prio_store !== 1'b1 && cyc < 5000) begin
			@(posedge clk_sys);
			cyc++;
			if (conv_clk_en === 1'b1) begin
				pulses++;
				if (sample_hold === 1'b1) sh_pulses++;
				if (prio_busy === 1'b1) busy_pulses++;
				if (pulses > 1) gap = cyc - last;
				last = cyc;
			end
		end
		if (cyc >= 5000) chk("store seen", 16'h1, 16'h0);
		chk("busy at store", 16'h0, {15'h0, prio_busy});
		@(posedge clk_sys);
		chk("store pulse width", 16'h0, {15'h0, prio_store});
	endtask

	task automatic t_reset();
		logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, CLK_SET_RST, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd_chk("reset value", i[2:0], exp[i]);
		end
		bus_wr(ADR_CLK_SET, 8'hFF);
		rd_chk("clock setting", ADR_CLK_SET, 8'hF7);
		$display("test reset done");
	endtask

	task automatic t_timing();
		logic [3:0] codes [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h3, 4'hC, 4'hD};
		int clks [7] = '{8, 16, 24, 32, 64, 128, 512};
		for (int i = 0; i < 7; i++) begin
			run_conv(codes[i], 3'h0, 10'h001);
			chk("conversion clocks", 16'(clks[i] + 38), 16'(pulses));
			chk("sample-hold clocks", 16'(clks[i]), 16'(sh_pulses));
			chk("busy clocks", 16'(clks[i] + 38), 16'(busy_pulses));
			chk("undivided spacing", 16'h1, 16'(gap));
		end
		run_conv(4'h8, 3'h1, 10'h001);
		chk("div2 spacing", 16'h2, 16'(gap));
		chk("div2 clocks", 16'd46, 16'(pulses));
		run_conv(4'h8, 3'h2, 10'h001);
		chk("div4 spacing", 16'h4, 16'(gap));
		$display("test timing done");
	endtask

	task automatic t_result();
		bus_rd(ADR_PRIO_HI, rd);
		bus_rd(ADR_PRIO_LO, rd);
		run_conv(4'h8, 3'h0, 10'h2A5);
		chk("result bits", 16'h02A5, {6'h0, prio_result_bits});
		rd_chk("result high", ADR_PRIO_HI, 8'hA9);
		rd_chk("result low", ADR_PRIO_LO, 8'h41);
		rd_chk("low after read", ADR_PRIO_LO, 8'h40);
		// Second store lands on an unread result
		run_conv(4'h8, 3'h0, 10'h3FF);
		run_conv(4'h8, 3'h0, 10'h155);
		rd_chk("overrun high", ADR_PRIO_HI, 8'h55);
		rd_chk("overrun low", ADR_PRIO_LO, 8'h43);
		rd_chk("overrun cleared", ADR_PRIO_LO, 8'h40);
		$display("test result done");
	endtask

	task automatic t_cmp();
		logic [2:0] b;
		for (int g = 0; g < 2; g++) begin
			b = 3'(2 + 2 * g);
			monitor_enable <= 2'h0;
			bus_wr(b + 3'h1, 8'hC3);
			bus_wr(b, 8'hFF);
			rd_chk("compare low", b, 8'hC0);
			rd_chk("compare high", b + 3'h1, 8'hC3);
			chk("compare out", 16'h030F, {6'h0, g == 0 ? compare0_bits : compare1_bits});
			// Monitor enabled: writes are refused
			monitor_enable[g] <= 1'b1;
			bus_wr(b + 3'h1, 8'h12);
			rd_chk("locked compare", b + 3'h1, 8'hC3);
		end
		monitor_enable <= 2'h0;
		$display("test compare done");
	endtask

	// Watchdog sized well above the expected run of under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_timing();
		t_result();
		t_cmp();
		conclude();
	end
endmodule
